//--- common/ebps_pkg.sv
package ebps_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] EBPS_OFS_BUS_CTRL = 8'h00;
	localparam logic [7:0] EBPS_OFS_PE_PULLUP = 8'h04;
	localparam logic [7:0] EBPS_OFS_PA_PULLUP = 8'h08;
	localparam logic [7:0] EBPS_OFS_PB_PULLUP = 8'h0C;
	localparam logic [7:0] EBPS_OFS_PB_PERIPH = 8'h10;
	localparam logic [7:0] EBPS_OFS_PE_PERIPH = 8'h14;
	localparam logic [7:0] EBPS_OFS_PA_PERIPH = 8'h18;
	localparam logic [7:0] EBPS_OFS_PF_PERIPH = 8'h1C;
	localparam logic [7:0] EBPS_OFS_PIN_STATUS = 8'h20;

	// ---------------------------------------------------------------
	// Field positions and widths
	// ---------------------------------------------------------------
	localparam int EBPS_BUS_DRIVE_BIT = 0;
	localparam int EBPS_PE_LO = 2;
	localparam int EBPS_PE_W = 2;
	localparam int EBPS_PA_W = 8;
	localparam int EBPS_PF_LO = 9;
	localparam int EBPS_PF_W = 7;
	localparam int EBPS_PIN_W = 18;
	localparam int EBPS_PB0_IDX = 10;
	localparam int EBPS_D0_IDX = 11;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic EBPS_RST_BUS_DRIVE = 1'b0;
	localparam logic [1:0] EBPS_RST_PE_PERIPH = 2'h3;
	localparam logic [7:0] EBPS_RST_PA_PERIPH = 8'hFF;
	localparam logic [6:0] EBPS_RST_PF_PERIPH = 7'h7F;
	localparam logic [7:0] EBPS_RST_PULLUP = 8'h00;

	typedef enum logic [1:0] {
		EBPS_ST_RESET,
		EBPS_ST_SYNC,
		EBPS_ST_STRAP,
		EBPS_ST_RUN
	} ebps_state_t;

endpackage

//--- rtl/ebps_sync.sv
`timescale 1ns/10ps
module ebps_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // ebps_sync

//--- rtl/ebps_top.sv
`timescale 1ns/10ps
module ebps_top (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Reset-time straps
	input wire logic external_boot_select_i,
	input wire logic ext_bus_width_mode_i,
	input wire logic flash_secure_i,
	// External memory interface core side
	input wire logic bus_active_i,
	input wire logic bus_write_i,
	input wire logic [16:6] bus_addr_i,
	input wire logic [6:0] bus_wdata_i,
	output logic [6:0] bus_rdata_o,
	input wire logic [2:0] bus_strobe_i,
	// GPIO side
	input wire logic [ebps_pkg::EBPS_PIN_W-1:0] gpio_out_i,
	input wire logic [ebps_pkg::EBPS_PIN_W-1:0] gpio_dir_out_i,
	output logic [ebps_pkg::EBPS_PIN_W-1:0] gpio_in_o,
	// Pads: pin order A6..A15, A16/PB0, D0..D6
	input wire logic [ebps_pkg::EBPS_PIN_W-1:0] pad_i,
	output logic [ebps_pkg::EBPS_PIN_W-1:0] pad_o,
	output logic [ebps_pkg::EBPS_PIN_W-1:0] pad_oe_n_o,
	output logic [ebps_pkg::EBPS_PIN_W-1:0] pad_pullup_en_o,
	output logic [2:0] strobe_o,
	output logic [2:0] strobe_oe_n_o
);
	import ebps_pkg::*;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic bus_drive_always_q;
	logic [EBPS_PE_W-1:0] port_e_pullup_ctrl_q;
	logic [EBPS_PA_W-1:0] port_a_pullup_ctrl_q;
	logic port_b_pullup_ctrl_q;
	logic port_b_periph_enable_q;
	logic [EBPS_PE_W-1:0] port_e_periph_q;
	logic [EBPS_PA_W-1:0] port_a_periph_q;
	logic [EBPS_PF_W-1:0] port_f_periph_q;
	logic [6:0] rdata_q;
	logic [31:0] prdata_q;
	ebps_state_t state_q;
	ebps_state_t state_d;

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	logic [2:0] strap_s;
	logic [EBPS_PIN_W-1:0] pad_s;

	ebps_sync #(.W(3)) u_strap_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.async_i({flash_secure_i, ext_bus_width_mode_i,
			external_boot_select_i}),
		.sync_o(strap_s)
	);

	ebps_sync #(.W(EBPS_PIN_W)) u_pad_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.async_i(pad_i),
		.sync_o(pad_s)
	);

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// One register hit per aligned word offset
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction

	wire wr_en = psel_i && penable_i && pwrite_i;
	wire sel_ctrl = addr_hit(paddr_i, EBPS_OFS_BUS_CTRL);
	wire sel_pe_pu = addr_hit(paddr_i, EBPS_OFS_PE_PULLUP);
	wire sel_pa_pu = addr_hit(paddr_i, EBPS_OFS_PA_PULLUP);
	wire sel_pb_pu = addr_hit(paddr_i, EBPS_OFS_PB_PULLUP);
	wire sel_pb_per = addr_hit(paddr_i, EBPS_OFS_PB_PERIPH);
	wire sel_pe_per = addr_hit(paddr_i, EBPS_OFS_PE_PERIPH);
	wire sel_pa_per = addr_hit(paddr_i, EBPS_OFS_PA_PERIPH);
	wire sel_pf_per = addr_hit(paddr_i, EBPS_OFS_PF_PERIPH);
	wire sel_stat = addr_hit(paddr_i, EBPS_OFS_PIN_STATUS);
	wire sel_any = sel_ctrl | sel_pe_pu | sel_pa_pu | sel_pb_pu | sel_pb_per
		| sel_pe_per | sel_pa_per | sel_pf_per | sel_stat;

	// Pin function vector: one marks bus function
	wire [EBPS_PIN_W-1:0] bus_fn = {port_f_periph_q, port_b_periph_enable_q,
		port_a_periph_q, port_e_periph_q};

	wire [31:0] rd_mux =
		sel_ctrl ? {31'h0, bus_drive_always_q} :
		sel_pe_pu ? {28'h0, port_e_pullup_ctrl_q, 2'h0} :
		sel_pa_pu ? {24'h0, port_a_pullup_ctrl_q} :
		sel_pb_pu ? {31'h0, port_b_pullup_ctrl_q} :
		sel_pb_per ? {31'h0, port_b_periph_enable_q} :
		sel_pe_per ? {28'h0, port_e_periph_q, 2'h0} :
		sel_pa_per ? {24'h0, port_a_periph_q} :
		sel_pf_per ? {16'h0, port_f_periph_q, 9'h0} :
		sel_stat ? {14'h0, pad_s} : 32'h0;

	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !sel_any;
	assign prdata_o = prdata_q;

	// ---------------------------------------------------------------
	// Reset-time strap capture
	// ---------------------------------------------------------------
	// Address 16 in use on external boot, or on internal boot with ext_bus_width_mode_i set and flash not secured
	wire pb0_strap_bus = strap_s[0] | (strap_s[1] & ~strap_s[2]);

	always_comb begin
		state_d = state_q;
		case (state_q)
			// Two cycles let the strap synchroniser settle
			EBPS_ST_RESET: state_d = EBPS_ST_SYNC;
			EBPS_ST_SYNC: state_d = EBPS_ST_STRAP;
			EBPS_ST_STRAP: state_d = EBPS_ST_RUN;
			EBPS_ST_RUN: state_d = EBPS_ST_RUN;
			default: state_d = EBPS_ST_RESET;
		endcase
	end

	// ---------------------------------------------------------------
	// Write strobes
	// ---------------------------------------------------------------
	wire wr_ctrl = wr_en & sel_ctrl;
	wire wr_pe_pu = wr_en & sel_pe_pu;
	wire wr_pa_pu = wr_en & sel_pa_pu;
	wire wr_pb_pu = wr_en & sel_pb_pu;
	wire wr_pb_per = wr_en & sel_pb_per;
	wire wr_pe_per = wr_en & sel_pe_per;
	wire wr_pa_per = wr_en & sel_pa_per;
	wire wr_pf_per = wr_en & sel_pf_per;
	// Strap capture outranks a write landing in the same cycle
	wire strap_take = state_q == EBPS_ST_STRAP;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= EBPS_ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ---------------------------------------------------------------
	// Bus control
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_drive_always_q <= EBPS_RST_BUS_DRIVE;
		end else if (wr_ctrl) begin
			bus_drive_always_q <= pwdata_i[EBPS_BUS_DRIVE_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Pull-up controls
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_e_pullup_ctrl_q <= EBPS_RST_PULLUP[EBPS_PE_W-1:0];
		end else if (wr_pe_pu) begin
			port_e_pullup_ctrl_q <= pwdata_i[EBPS_PE_LO +: EBPS_PE_W];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_a_pullup_ctrl_q <= EBPS_RST_PULLUP;
		end else if (wr_pa_pu) begin
			port_a_pullup_ctrl_q <= pwdata_i[EBPS_PA_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_b_pullup_ctrl_q <= EBPS_RST_PULLUP[0];
		end else if (wr_pb_pu) begin
			port_b_pullup_ctrl_q <= pwdata_i[0];
		end
	end

	// ---------------------------------------------------------------
	// Pin function selects
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_b_periph_enable_q <= 1'b0;
		end else if (strap_take) begin
			port_b_periph_enable_q <= pb0_strap_bus;
		end else if (wr_pb_per) begin
			port_b_periph_enable_q <= pwdata_i[0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_e_periph_q <= EBPS_RST_PE_PERIPH;
		end else if (wr_pe_per) begin
			port_e_periph_q <= pwdata_i[EBPS_PE_LO +: EBPS_PE_W];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_a_periph_q <= EBPS_RST_PA_PERIPH;
		end else if (wr_pa_per) begin
			port_a_periph_q <= pwdata_i[EBPS_PA_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_f_periph_q <= EBPS_RST_PF_PERIPH;
		end else if (wr_pf_per) begin
			port_f_periph_q <= pwdata_i[EBPS_PF_LO +: EBPS_PF_W];
		end
	end

	// ---------------------------------------------------------------
	// APB read data
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_q <= 32'h0;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_q <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// Pin muxing
	// ---------------------------------------------------------------
	wire bus_drive = bus_active_i | bus_drive_always_q;
	wire data_drive = bus_drive & (bus_write_i | ~bus_active_i);
	wire [EBPS_PIN_W-1:0] bus_val = {bus_wdata_i, bus_addr_i};
	wire [EBPS_PIN_W-1:0] pu_off = {7'h0, port_b_pullup_ctrl_q,
		port_a_pullup_ctrl_q, port_e_pullup_ctrl_q};

	genvar gi;
	generate
		for (gi = 0; gi < EBPS_PIN_W; gi++) begin : g_pin
			// Address pins vs data pins differ only in the drive term
			wire drv = (gi < EBPS_D0_IDX) ? bus_drive : data_drive;
			assign pad_o[gi] = bus_fn[gi] ? bus_val[gi] : gpio_out_i[gi];
			assign pad_oe_n_o[gi] = bus_fn[gi] ? ~drv
				: ~gpio_dir_out_i[gi];
			assign gpio_in_o[gi] = bus_fn[gi] ? 1'b0 : pad_s[gi];
			// Set control bit disables pull-up
			assign pad_pullup_en_o[gi] = ~pu_off[gi];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Data read capture
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 7'h0;
		end else if (bus_active_i && !bus_write_i) begin
			rdata_q <= pad_s[EBPS_PIN_W-1:EBPS_D0_IDX]
				& port_f_periph_q;
		end
	end
	assign bus_rdata_o = rdata_q;

	// ---------------------------------------------------------------
	// Control strobes
	// ---------------------------------------------------------------
	assign strobe_o = bus_strobe_i;
	assign strobe_oe_n_o = {3{~bus_drive}};

endmodule // ebps_top

//--- sim/ebps_checker.sv
`timescale 1ns/10ps
module ebps_checker (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic bus_active_i,
	input wire logic bus_write_i,
	input wire logic [16:6] bus_addr_i,
	input wire logic [6:0] bus_wdata_i,
	input wire logic [17:0] gpio_dir_out_i,
	input wire logic [17:0] pad_o,
	input wire logic [17:0] pad_oe_n_o,
	input wire logic [17:0] pad_pullup_en_o,
	input wire logic [2:0] strobe_oe_n_o
);
	logic drv_q;
	logic [17:0] fn_q;
	logic [10:0] pu_q;
	wire on_w = bus_active_i | drv_q;
	// Pin 10 left out: its function hangs on the straps
	wire [17:0] bus_w = fn_q & 18'h3FBFF;
	wire [17:0] gp_w = ~fn_q & 18'h3FBFF;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drv_q <= 1'b0;
			fn_q <= 18'h3FFFF;
			pu_q <= 11'h000;
		end else if (psel_i && penable_i && pwrite_i) begin
			case (paddr_i)
			8'h00: drv_q <= pwdata_i[0];
			8'h04: pu_q[1:0] <= pwdata_i[3:2];
			8'h08: pu_q[9:2] <= pwdata_i[7:0];
			8'h0C: pu_q[10] <= pwdata_i[0];
			8'h14: fn_q[1:0] <= pwdata_i[3:2];
			8'h18: fn_q[9:2] <= pwdata_i[7:0];
			8'h1C: fn_q[17:11] <= pwdata_i[15:9];
			default: ;
			endcase
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	addr_float_a: assert property (
		!on_w |-> &(pad_oe_n_o[9:0] | ~bus_w[9:0])) else $error("addr float");
	addr_drive_a: assert property (
		on_w |-> (pad_oe_n_o[9:0] & bus_w[9:0]) == 10'h0) else $error("addr oe");
	addr_value_a: assert property (
		bus_active_i |-> ((pad_o[9:0] ^ bus_addr_i[15:6]) & bus_w[9:0]) == 10'h0)
		else $error("addr value");
	data_float_a: assert property (
		!on_w || (bus_active_i && !bus_write_i)
		|-> &(pad_oe_n_o[17:11] | ~bus_w[17:11])) else $error("data float");
	data_write_a: assert property (
		bus_active_i && bus_write_i |-> ((pad_oe_n_o[17:11]
		| (pad_o[17:11] ^ bus_wdata_i)) & bus_w[17:11]) == 7'h0) else $error("data");
	strobe_oe_a: assert property (
		strobe_oe_n_o == (on_w ? 3'h0 : 3'h7)) else $error("strobe oe");
	gpio_oe_a: assert property (
		((pad_oe_n_o ^ ~gpio_dir_out_i) & gp_w) == 18'h0) else $error("gpio oe");
	pullup_off_a: assert property (
		(pad_pullup_en_o[10:0] & pu_q) == 11'h0) else $error("pull-up on");
endmodule // ebps_checker
bind ebps_top ebps_checker u_chk (.clk_sys_i, .rstn_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .bus_active_i, .bus_write_i, .bus_addr_i,
	.bus_wdata_i, .gpio_dir_out_i, .pad_o, .pad_oe_n_o, .pad_pullup_en_o,
	.strobe_oe_n_o);

//--- sim/ebps_mem_model.sv
`timescale 1ns/10ps
module ebps_mem_model (
	input wire logic clk_sys_i,
	input wire logic [17:0] pad_o,
	input wire logic [2:0] strobe_o,
	input wire logic [2:0] strobe_oe_n_o,
	output logic [6:0] mem_d_o
);
	logic [6:0] last_q = 7'h55;
	// Answers on a driven read strobe, else a bus that toggles
	wire rd_w = strobe_o[0] & ~strobe_oe_n_o[0];
	assign mem_d_o = rd_w ? (pad_o[6:0] ^ 7'h2A) : ~last_q;
	always @(posedge clk_sys_i) begin
		last_q <= mem_d_o;
	end
endmodule // ebps_mem_model

//--- sim/ebps_top_tb.sv
`timescale 1ns/10ps
module ebps_top_tb;
	logic clk_sys_i, pready_o, pslverr_o, er, strap_w;
	logic rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic external_boot_select_i = 1'b1, ext_bus_width_mode_i = 1'b0;
	logic flash_secure_i = 1'b0, bus_active_i = 1'b0, bus_write_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic [16:6] bus_addr_i = 11'h000;
	logic [6:0] bus_wdata_i = 7'h00, bus_rdata_o, mem_d;
	logic [2:0] bus_strobe_i = 3'h0, strobe_o, strobe_oe_n_o;
	logic [17:0] gpio_out_i = 18'h2AAAA, gpio_dir_out_i = 18'h0;
	logic [17:0] ext_q = 18'h0F0F3, gpio_in_o, pad_i, pad_o, pad_oe_n_o;
	logic [17:0] pad_pullup_en_o, exp_w;
	int checks = 0, bad_count = 0, cyc = 0;
	logic [23:0] rows [6] = '{24'h1FFFFF, 24'h43F800, 24'h600000,
		24'h800000, 24'hC3F800, 24'hE00000};
	assign pad_i = (~pad_oe_n_o & pad_o) | (pad_oe_n_o & {mem_d, ext_q[10:0]});
	ebps_top dut (.clk_sys_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .external_boot_select_i,
		.ext_bus_width_mode_i, .flash_secure_i, .bus_active_i, .bus_write_i,
		.bus_addr_i, .bus_wdata_i, .bus_rdata_o, .bus_strobe_i, .gpio_out_i,
		.gpio_dir_out_i, .gpio_in_o, .pad_i, .pad_o, .pad_oe_n_o,
		.pad_pullup_en_o, .strobe_o, .strobe_oe_n_o);
	ebps_mem_model u_mem (.clk_sys_i, .pad_o, .strobe_o, .strobe_oe_n_o,
		.mem_d_o(mem_d));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1) @(posedge clk_sys_i);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rst;
		@(posedge clk_sys_i);
		rstn_i <= 1'b0;
		repeat (16) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
	endtask
	task automatic final_report;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		rst();
		for (int i = 0; i < 6; i++) begin
			if (i == 3) apb(1'b1, 8'h00, 32'h1);
			@(posedge clk_sys_i);
			bus_active_i <= rows[i][22];
			bus_write_i <= rows[i][21];
			bus_addr_i <= 11'h2A5 + 11'(i);
			bus_wdata_i <= 7'h33 ^ 7'(i);
			@(negedge clk_sys_i);
			chk({strobe_oe_n_o, pad_oe_n_o}, rows[i][20:0]);
			if (rows[i][22]) chk(pad_o[10:0], bus_addr_i);
			if (rows[i][21]) chk(pad_o[17:11], bus_wdata_i);
		end
		@(posedge clk_sys_i);
		bus_write_i <= 1'b0;
		bus_strobe_i <= 3'h1;
		repeat (5) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(bus_rdata_o, bus_addr_i[12:6] ^ 7'h2A);
		chk(strobe_o, 3'h1);
		@(posedge clk_sys_i);
		bus_strobe_i <= 3'h0;
		gpio_dir_out_i <= 18'h00155;
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h18, 32'h0);
		apb(1'b1, 8'h10, 32'h0);
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		exp_w = (gpio_dir_out_i & gpio_out_i) | (~gpio_dir_out_i & ext_q);
		chk(pad_oe_n_o[10:0] ^ gpio_dir_out_i[10:0], 11'h7FF);
		chk(gpio_in_o, {7'h00, exp_w[10:0]});
		@(posedge clk_sys_i);
		gpio_dir_out_i <= 18'h0;
		apb(1'b1, 8'h04, 32'hC);
		apb(1'b1, 8'h08, 32'hA5);
		apb(1'b1, 8'h0C, 32'h1);
		@(negedge clk_sys_i);
		chk(pad_pullup_en_o[10:0], 11'h168);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'hA5);
		apb(1'b0, 8'h24, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h1C, 32'h1200);
		apb(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h1200);
		apb(1'b1, 8'h10, 32'h1);
		@(negedge clk_sys_i);
		chk(pad_oe_n_o[10], 1'b0);
		for (int s = 0; s < 8; s++) begin
			@(posedge clk_sys_i);
			external_boot_select_i <= s[2];
			ext_bus_width_mode_i <= s[1];
			flash_secure_i <= s[0];
			strap_w = s[2] | (s[1] & ~s[0]);
			rst();
			@(negedge clk_sys_i);
			chk(pad_oe_n_o[10], !strap_w);
		end
		final_report();
	end
endmodule // ebps_top_tb
